/* pkg/fault_escalation_pkg.sv */
package fault_escalation_pkg;
	localparam int VEC_W = 8;
	localparam int ADDR_W = 32;
	localparam int SEL_W = 16;
	localparam int ERR_W = 32;
	localparam logic [VEC_W-1:0] VEC_DIVIDE = 8'h00;
	localparam logic [VEC_W-1:0] VEC_COPROC_UNAVAIL = 8'h07;
	localparam logic [VEC_W-1:0] VEC_DOUBLE_FAULT = 8'h08;
	localparam logic [VEC_W-1:0] VEC_SEG_OVERRUN = 8'h09;
	localparam logic [VEC_W-1:0] VEC_CONTRIB_LO = 8'h0a;
	localparam logic [VEC_W-1:0] VEC_CONTRIB_HI = 8'h0d;
	localparam logic [VEC_W-1:0] VEC_GENERAL_PROT = 8'h0d;
	localparam logic [VEC_W-1:0] VEC_PAGE_FAULT = 8'h0e;
	localparam logic [ERR_W-1:0] DOUBLE_FAULT_ERR_CODE = 32'h0000_0000;

	typedef enum logic [1:0] {
		CLASS_BENIGN = 2'b00,
		CLASS_CONTRIB = 2'b01,
		CLASS_PAGE = 2'b10
	} fault_class_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELIVER = 2'b01,
		ST_DELIVER_DBL = 2'b10,
		ST_SHUTDOWN = 2'b11
	} esc_state_t;
endpackage

/* verilog/fault_escalation_shutdown_unit.sv */
`timescale 1ns/10ps
// Functional notes
// [RULE_01] fpu instruction with emulation flag set raises coprocessor-unavailable fault.
// [RULE_02] wait raises that fault when monitor and task-switched flags both set.
// [RULE_03] no error code; saved selector and offset point at faulting instruction.
// [RULE_04] faulting instruction is suppressed, no architectural state changes.
// [RULE_05] handler may emulate, or save context, clear task flag, resume.
// [RULE_06] vectors 0,10-13 contributory, 14 page fault, all others benign.
// [RULE_07] double fault on contrib-after-contrib, or contrib/page after page fault.
// [RULE_08] double fault goes out on vector 8 as an abort, not restartable.
// [RULE_09] double fault always pushes error code zero.
// [RULE_10] saved selector and offset for double fault are undefined.
// [RULE_11] escalation only during handler delivery; prefetch faults excluded.
// [RULE_12] exception while invoking double-fault handler enters shutdown.
// [RULE_13] shutdown halts until nmi, system-mgmt interrupt, hardware reset or init.
// [RULE_14] entering shutdown issues a distinct shutdown bus cycle.
// [RULE_15] events pending in shutdown are held until after wake is processed.
// [RULE_16] shutdown inside nmi handler or system-mgmt state wakes only on reset.
// [RULE_17] corrupted delivery state at double fault: no handler, reset only.
// [RULE_18] vector 9 never generated; operand-transfer violation becomes vector 13.
// [RULE_19] delivery state records class; cleared when handler starts executing.
module fault_escalation_shutdown_unit
	import fault_escalation_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fpu_emulation_flag,
	input wire logic task_switched_flag,
	input wire logic monitor_coprocessor_flag,
	input wire logic fpu_insn_valid,
	input wire logic fpu_sync_wait,
	input wire logic [fault_escalation_pkg::SEL_W-1:0] insn_selector,
	input wire logic [fault_escalation_pkg::ADDR_W-1:0] insn_offset,
	input wire logic exc_valid,
	input wire logic [fault_escalation_pkg::VEC_W-1:0] exc_vector,
	input wire logic exc_has_err,
	input wire logic [fault_escalation_pkg::ERR_W-1:0] exc_err_code,
	input wire logic exc_prefetch,
	input wire logic operand_xfer_violation,
	input wire logic handler_started,
	input wire logic delivery_state_corrupt,
	input wire logic in_nmi_handler,
	input wire logic system_mgmt_state,
	input wire logic nmi_wake,
	input wire logic system_mgmt_interrupt,
	input wire logic init_request,
	input wire logic pending_event,
	output logic insn_suppress,
	output logic deliver_valid,
	output logic [fault_escalation_pkg::VEC_W-1:0] deliver_vector,
	output logic deliver_push_err,
	output logic [fault_escalation_pkg::ERR_W-1:0] deliver_err_code,
	output logic deliver_abort,
	output logic [fault_escalation_pkg::SEL_W-1:0] deliver_selector,
	output logic [fault_escalation_pkg::ADDR_W-1:0] deliver_offset,
	output logic shutdown_cycle,
	output logic halted,
	output logic wake_valid,
	output logic [1:0] wake_cause,
	output logic pending_release,
	output logic reset_only_lock
);
	import fault_escalation_pkg::*;

	function automatic fault_class_t classify(input logic [VEC_W-1:0] v);
		if (v == VEC_PAGE_FAULT)
			return CLASS_PAGE; // RULE_06
		else if (v == VEC_DIVIDE || (v >= VEC_CONTRIB_LO && v <= VEC_CONTRIB_HI))
			return CLASS_CONTRIB; // RULE_06
		else
			return CLASS_BENIGN; // RULE_06
	endfunction

	esc_state_t state_reg;
	fault_class_t class_reg;
	logic lock_reg;
	logic held_reg;

	logic cop_fault;
	logic [VEC_W-1:0] eff_vector;
	fault_class_t eff_class;
	logic raise;
	logic escalate;
	logic wake_any;

	// wait ignores emulation; other fpu ops fault only on emulation
	// the wait qualifier is only meaningful while an instruction is actually valid
	assign cop_fault = fpu_insn_valid
		&& ((fpu_sync_wait && monitor_coprocessor_flag && task_switched_flag) // RULE_02
		|| (!fpu_sync_wait && fpu_emulation_flag)); // RULE_01
	assign insn_suppress = cop_fault; // RULE_04

	always_comb begin
		eff_vector = exc_vector;
		if (operand_xfer_violation || exc_vector == VEC_SEG_OVERRUN)
			eff_vector = VEC_GENERAL_PROT; // RULE_18
		else if (cop_fault)
			eff_vector = VEC_COPROC_UNAVAIL; // RULE_01
	end

	// a coprocessor fault takes priority over an external exception in the same cycle, except vector 9 or an operand-transfer violation, which become vector 13
	assign raise = exc_valid || cop_fault || operand_xfer_violation;
	assign eff_class = classify(eff_vector);
	// prefetch faults bypass the matrix and are handled serially
	assign escalate = state_reg == ST_DELIVER && !exc_prefetch // RULE_11
		&& ((class_reg == CLASS_CONTRIB && eff_class == CLASS_CONTRIB)
		|| (class_reg == CLASS_PAGE && eff_class != CLASS_BENIGN)); // RULE_07
	assign wake_any = nmi_wake || system_mgmt_interrupt || init_request; // RULE_13

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			class_reg <= CLASS_BENIGN;
		end else begin
			unique case (state_reg)
				ST_IDLE, ST_DELIVER: begin
					if (raise && escalate && delivery_state_corrupt) begin
						state_reg <= ST_SHUTDOWN; // RULE_17
					end else if (raise && escalate) begin
						state_reg <= ST_DELIVER_DBL; // RULE_07
					end else if (raise) begin
						state_reg <= ST_DELIVER; // RULE_19
						class_reg <= eff_class; // RULE_19
					end else if (handler_started) begin
						state_reg <= ST_IDLE; // RULE_19
						class_reg <= CLASS_BENIGN;
					end
				end
				ST_DELIVER_DBL: begin
					if (raise)
						state_reg <= ST_SHUTDOWN; // RULE_12
					else if (handler_started)
						state_reg <= ST_IDLE;
				end
				ST_SHUTDOWN: begin
					if (wake_any && !lock_reg) begin
						state_reg <= ST_IDLE; // RULE_13
						class_reg <= CLASS_BENIGN;
					end
				end
			endcase
		end
	end

	// lock captured on entry; corrupted machine state also recovers only by reset
	always_ff @(posedge clk) begin
		if (rst)
			lock_reg <= 1'b0;
		else if (state_reg != ST_SHUTDOWN) begin
			if ((state_reg == ST_DELIVER_DBL && raise && (in_nmi_handler || system_mgmt_state)) // RULE_16
				|| (raise && escalate && delivery_state_corrupt)) // RULE_17
				lock_reg <= 1'b1;
			else
				lock_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			deliver_valid <= 1'b0;
			deliver_vector <= '0;
			deliver_push_err <= 1'b0;
			deliver_err_code <= '0;
			deliver_abort <= 1'b0;
			deliver_selector <= '0;
			deliver_offset <= '0;
		end else begin
			deliver_valid <= 1'b0;
			if (state_reg != ST_SHUTDOWN && state_reg != ST_DELIVER_DBL && raise
				&& !(escalate && delivery_state_corrupt)) begin
				deliver_valid <= 1'b1;
				if (escalate) begin
					deliver_vector <= VEC_DOUBLE_FAULT; // RULE_08
					deliver_abort <= 1'b1; // RULE_08
					deliver_push_err <= 1'b1; // RULE_09
					deliver_err_code <= DOUBLE_FAULT_ERR_CODE; // RULE_09
					// selector/offset left as they were: undefined for this vector
					deliver_selector <= deliver_selector; // RULE_10
					deliver_offset <= deliver_offset; // RULE_10
				end else begin
					deliver_vector <= eff_vector;
					deliver_abort <= 1'b0;
					deliver_push_err <= (eff_vector == VEC_COPROC_UNAVAIL) ? 1'b0 : exc_has_err; // RULE_03
					deliver_err_code <= (eff_vector == VEC_COPROC_UNAVAIL) ? '0 : exc_err_code; // RULE_03
					deliver_selector <= insn_selector; // RULE_03
					deliver_offset <= insn_offset; // RULE_03
				end
			end
		end
	end

	// one-cycle special bus cycle on entry
	always_ff @(posedge clk) begin
		if (rst)
			shutdown_cycle <= 1'b0;
		else
			shutdown_cycle <= state_reg != ST_SHUTDOWN
				&& ((state_reg == ST_DELIVER_DBL && raise) || (raise && escalate && delivery_state_corrupt)); // RULE_14
	end

	// pending events are parked while halted and released once the wake pulse has dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			held_reg <= 1'b0;
			wake_valid <= 1'b0;
			wake_cause <= 2'b00;
			pending_release <= 1'b0;
		end else begin
			wake_valid <= 1'b0;
			pending_release <= 1'b0;
			if (state_reg == ST_SHUTDOWN) begin
				if (pending_event)
					held_reg <= 1'b1; // RULE_15
				if (wake_any && !lock_reg) begin
					wake_valid <= 1'b1;
					wake_cause <= nmi_wake ? 2'b01 : (system_mgmt_interrupt ? 2'b10 : 2'b11);
				end
			end else if (held_reg && !wake_valid) begin
				held_reg <= 1'b0;
				pending_release <= 1'b1; // RULE_15
			end
		end
	end

	assign halted = state_reg == ST_SHUTDOWN; // RULE_13
	assign reset_only_lock = lock_reg;
endmodule

/* bench/fault_escalation_checker_assertions.sv */
`timescale 1ns/10ps
module fault_escalation_checker
	import fault_escalation_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fpu_emulation_flag,
	input wire logic task_switched_flag,
	input wire logic monitor_coprocessor_flag,
	input wire logic fpu_insn_valid,
	input wire logic fpu_sync_wait,
	input wire logic nmi_wake,
	input wire logic insn_suppress,
	input wire logic deliver_valid,
	input wire logic [fault_escalation_pkg::VEC_W-1:0] deliver_vector,
	input wire logic deliver_abort,
	input wire logic shutdown_cycle,
	input wire logic halted,
	input wire logic wake_valid,
	input wire logic pending_release,
	input wire logic reset_only_lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_emul_fault: assert property (fpu_insn_valid && fpu_emulation_flag && !fpu_sync_wait && !halted |-> insn_suppress)
		else $error("fpu op with emulation set not cancelled");
	chk_wait_fault: assert property (fpu_insn_valid && fpu_sync_wait && monitor_coprocessor_flag && task_switched_flag && !halted |-> insn_suppress)
		else $error("wait with monitor and task flags not cancelled");
	// abort still standing hides a possible double-fault delivery in flight
	chk_cop_vector: assert property (insn_suppress && !halted && !deliver_abort |=> deliver_valid && deliver_vector == VEC_COPROC_UNAVAIL)
		else $error("cancelled instruction not delivered on coprocessor vector");
	chk_df_abort: assert property (deliver_valid && deliver_vector == VEC_DOUBLE_FAULT |-> deliver_abort)
		else $error("double fault not marked abort");
	chk_no_vec9: assert property (deliver_valid |-> deliver_vector != VEC_SEG_OVERRUN)
		else $error("vector 9 delivered");
	chk_shut_pulse: assert property ($rose(halted) |-> shutdown_cycle ##1 !shutdown_cycle)
		else $error("shutdown entry without single indication pulse");
	chk_halt_quiet: assert property (halted |-> !deliver_valid && !pending_release)
		else $error("activity while halted");
	chk_lock_wake: assert property (reset_only_lock && nmi_wake |=> halted && !wake_valid)
		else $error("wake accepted while locked");
	chk_nmi_wake: assert property (halted && !reset_only_lock && nmi_wake |=> wake_valid && !halted)
		else $error("nmi did not wake from shutdown");
	cover property (deliver_valid && deliver_abort);
	cover property (shutdown_cycle);
	cover property (wake_valid);
endmodule
bind fault_escalation_shutdown_unit fault_escalation_checker chk_i (.*);

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import fault_escalation_pkg::*;
	logic clk, rst, fpu_emulation_flag, task_switched_flag, monitor_coprocessor_flag, fpu_insn_valid, fpu_sync_wait;
	logic exc_valid, exc_has_err, exc_prefetch, operand_xfer_violation, handler_started, delivery_state_corrupt;
	logic in_nmi_handler, system_mgmt_state, nmi_wake, system_mgmt_interrupt, init_request, pending_event;
	logic insn_suppress, deliver_valid, deliver_push_err, deliver_abort, shutdown_cycle, halted, wake_valid;
	logic pending_release, reset_only_lock;
	logic [1:0] wake_cause;
	logic [SEL_W-1:0] insn_selector, deliver_selector;
	logic [ADDR_W-1:0] insn_offset, deliver_offset;
	logic [VEC_W-1:0] exc_vector, deliver_vector;
	logic [ERR_W-1:0] exc_err_code, deliver_err_code;
	int fail_count, samples_checked, cycles;
	// first raise, second raise, vector expected for the second
	logic [VEC_W-1:0] rows [8][3] = '{'{8'h00, 8'h0d, 8'h08}, '{8'h0e, 8'h0b, 8'h08}, '{8'h0e, 8'h0e, 8'h08},
		'{8'h0c, 8'h0e, 8'h0e}, '{8'h03, 8'h0a, 8'h0a}, '{8'h0d, 8'h01, 8'h01}, '{8'h02, 8'h09, 8'h0d},
		'{8'h0e, 8'h20, 8'h20}};
	fault_escalation_shutdown_unit DUT (.*);
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task chk(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task chk_vec(input logic [VEC_W-1:0] exp);
		samples_checked++;
		if (deliver_valid !== 1'b1 || deliver_vector !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t vector %h expected %h", $time, deliver_vector, exp);
		end
	endtask
	task step();
		@(posedge clk);
		#1;
	endtask
	task raise(input logic [VEC_W-1:0] v);
		exc_vector = v;
		exc_valid = 1;
		step();
	endtask
	task ack();
		handler_started = 1;
		step();
		handler_started = 0;
	endtask
	task do_reset();
		rst = 1;
		repeat (12) step();
		rst = 0;
	endtask
	task final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cop_try(input logic emul, input logic mon, input logic tsw, input logic w, input logic s);
		{fpu_emulation_flag, monitor_coprocessor_flag, task_switched_flag} = {emul, mon, tsw};
		{fpu_sync_wait, fpu_insn_valid} = {w, 1'b1};
		// error code offered alongside must not be pushed for this fault
		{insn_selector, insn_offset, exc_has_err, exc_err_code} = {16'h0123, 32'h0000_1234, 1'b1, 32'h0000_00a5};
		#5 chk(insn_suppress, s);
		step();
		fpu_insn_valid = 0;
		chk(deliver_valid, s);
		if (s) chk(deliver_vector === VEC_COPROC_UNAVAIL && !deliver_push_err && deliver_offset === 32'h0000_1234, 1'b1);
		if (s) chk(deliver_selector === 16'h0123, 1'b1);
		ack();
		task_switched_flag = 0;
	endtask
	task shut(input logic nmi_h, input logic sys_mgmt, input logic [1:0] k);
		pending_event = 1;
		raise(8'h0d);
		raise(8'h0d);
		exc_valid = 0;
		chk_vec(VEC_DOUBLE_FAULT);
		chk(deliver_push_err && deliver_abort && deliver_err_code === DOUBLE_FAULT_ERR_CODE, 1'b1);
		{in_nmi_handler, system_mgmt_state} = {nmi_h, sys_mgmt};
		raise(8'h03);
		exc_valid = 0;
		chk(shutdown_cycle && halted, 1'b1);
		raise(8'h0d);
		exc_valid = 0;
		chk(!deliver_valid && halted && !pending_release, 1'b1);
		{init_request, system_mgmt_interrupt, nmi_wake} = 3'b001 << (k - 2'd1);
		step();
		{init_request, system_mgmt_interrupt, nmi_wake} = '0;
		chk(wake_valid && wake_cause === k && !halted, !(nmi_h | sys_mgmt));
		step();
		// held events wait until the wake pulse itself has gone
		chk(pending_release, 1'b0);
		step();
		chk(pending_release, !(nmi_h | sys_mgmt));
		{pending_event, in_nmi_handler, system_mgmt_state} = '0;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles > 2000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		{fpu_emulation_flag, task_switched_flag, monitor_coprocessor_flag, fpu_insn_valid, fpu_sync_wait, insn_selector,
			insn_offset, exc_valid, exc_vector, exc_has_err, exc_err_code, exc_prefetch, operand_xfer_violation,
			handler_started, delivery_state_corrupt, in_nmi_handler, system_mgmt_state, nmi_wake,
			system_mgmt_interrupt, init_request, pending_event} = '0;
		do_reset();
		chk(deliver_valid || halted || reset_only_lock, 1'b0);
		foreach (rows[i]) begin
			raise(rows[i][0]);
			raise(rows[i][1]);
			exc_valid = 0;
			chk_vec(rows[i][2]);
			ack();
		end
		cop_try(1, 0, 0, 0, 1);
		cop_try(0, 1, 1, 1, 1);
		cop_try(0, 1, 0, 1, 0);
		operand_xfer_violation = 1;
		step();
		operand_xfer_violation = 0;
		chk_vec(VEC_GENERAL_PROT);
		ack();
		// prefetch fault after a page fault must not escalate
		raise(8'h0e);
		exc_prefetch = 1;
		raise(8'h0d);
		{exc_valid, exc_prefetch} = '0;
		chk_vec(8'h0d);
		ack();
		for (int k = 1; k < 4; k++) shut(1'b0, 1'b0, k[1:0]);
		shut(1'b1, 1'b0, 2'd1);
		chk(halted && reset_only_lock, 1'b1);
		do_reset();
		shut(1'b0, 1'b1, 2'd3);
		chk(halted && reset_only_lock && !wake_valid, 1'b1);
		do_reset();
		delivery_state_corrupt = 1;
		raise(8'h0d);
		raise(8'h0d);
		exc_valid = 0;
		chk(!deliver_valid && shutdown_cycle && reset_only_lock, 1'b1);
		do_reset();
		chk(halted || reset_only_lock, 1'b0);
		final_report();
	end
endmodule
